// file: ies_event_reg.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module ies_event_reg #(
    parameter int N_CTX        = 8,
    parameter int OVERLONG_CYC = ies_pkg::OVERLONG_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  clk_en,
    input  wire ies_pkg::ies_bus_req_s bus,
    input  wire ies_pkg::ies_src_s     src,
    input  wire ies_pkg::ies_cycle_in_s cyc,
    input  wire logic [N_CTX-1:0]      ctx_halt,
    output logic [31:0]                rdata,
    output logic                       irq,
    output logic                       cycle_start_source,
    output logic [N_CTX-1:0]           context_block
);
    if (N_CTX < 1 || OVERLONG_CYC < 1) begin : g_chk
        $error("ies_event_reg: bad parameter value");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [2:0] {
        CW_IDLE,
        CW_WAIT,
        CW_GAP,
        CW_SEEN,
        CW_LOST
    } ies_cyc_state_e;

    logic [31:0]    ev_q, ev_d;
    logic [31:0]    mask_q, mask_d;
    logic [31:0]    ctrl_q, ctrl_d;
    logic [31:0]    rdata_q, rdata_d;
    logic           irq_q, irq_d;
    logic [N_CTX-1:0] blk_q, blk_d;
    logic           lsb_q, lsb_d;
    ies_cyc_state_e cs_q, cs_d;

    logic [31:0]    hw_lvl;
    logic [31:0]    hw_rise;
    logic [31:0]    hw_set;
    logic [31:0]    sw_set;
    logic [31:0]    sw_clr;
    logic           late_en;
    logic           src_en;
    logic           tick;
    logic           start_seen;
    logic           mism_lvl;
    logic           lost_lvl;
    logic           overlong_fire;
    logic           fatal_lvl;

    assign late_en            = ctrl_q[ies_pkg::CTRL_LATE_EN];
    assign src_en             = ctrl_q[ies_pkg::CTRL_CYC_SRC];
    assign rdata              = rdata_q;
    assign irq                = irq_q;
    assign cycle_start_source = ctrl_q[ies_pkg::CTRL_CYC_SRC];
    assign context_block      = blk_q;

    ////////////////////////////////////////////////////////////////////////
    // cycle timing events
    always_comb begin
        lsb_d      = cyc.local_timer[ies_pkg::TIMER_CNT_LSB];
        tick       = lsb_d ^ lsb_q;
        start_seen = cyc.tx_start_begin | cyc.rx_start;
        mism_lvl   = cyc.rx_start &&
                     ({cyc.rx_seconds, cyc.rx_count} !=
                      cyc.local_timer[31:ies_pkg::TIMER_CNT_LSB]);
    end

    always_comb begin
        cs_d     = cs_q;
        lost_lvl = 1'b0;
        if (tick) begin
            // a period with no start is lost unless already predicted
            lost_lvl = (cs_q == CW_WAIT) || (cs_q == CW_GAP);
            cs_d     = CW_WAIT;
        end else begin
            unique case (cs_q)
                CW_IDLE: begin
                    cs_d = CW_IDLE;
                end
                CW_WAIT: begin
                    if (start_seen) begin
                        cs_d = CW_SEEN;
                    end else if (cyc.arb_reset_gap) begin
                        lost_lvl = 1'b1;
                        cs_d     = CW_LOST;
                    end else if (cyc.gap_end) begin
                        cs_d = CW_GAP;
                    end
                end
                CW_GAP: begin
                    if (start_seen) begin
                        cs_d = CW_SEEN;
                    end else if (cyc.gap_end || cyc.arb_reset_gap) begin
                        lost_lvl = 1'b1;
                        cs_d     = CW_LOST;
                    end
                end
                CW_SEEN: begin
                    cs_d = CW_SEEN;
                end
                CW_LOST: begin
                    cs_d = CW_LOST;
                end
            endcase
        end
    end

    ies_overlong_timer #(
        .LIMIT (OVERLONG_CYC)
    ) u_overlong (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .enable  (src_en),
        .start   (cyc.tx_start_begin),
        .stop    (cyc.gap_end),
        .fire    (overlong_fire)
    );

    ////////////////////////////////////////////////////////////////////////
    // hardware event sources
    always_comb begin
        fatal_lvl = (|ctx_halt) | src.other_halt;
        hw_lvl    = '0;
        hw_lvl[ies_pkg::BIT_EEPROM]   = src.eeprom_done;
        hw_lvl[ies_pkg::BIT_LATE_ACK] = late_en &
                                        (src.rx_fifo_host_data |
                                         src.phys_resp_busy |
                                         src.ack_tardy_sent);
        hw_lvl[ies_pkg::BIT_PHY_REG]  = src.phy_reg_byte_arrived;
        hw_lvl[ies_pkg::BIT_OVERLONG] = overlong_fire;
        hw_lvl[ies_pkg::BIT_FATAL]    = fatal_lvl;
        hw_lvl[ies_pkg::BIT_MISMATCH] = mism_lvl;
        hw_lvl[ies_pkg::BIT_MISSED]   = lost_lvl;
        hw_lvl[ies_pkg::BIT_TICK]     = tick;
    end

    ies_edge_detect #(
        .W (32)
    ) u_edge (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .level   (hw_lvl),
        .rise    (hw_rise)
    );

    always_comb begin
        hw_set = hw_rise & ies_pkg::EVENT_HW;
        if (!late_en) begin
            hw_set[ies_pkg::BIT_LATE_ACK] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes and event state
    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (bus.wr && bus.addr == ies_pkg::OFS_EVENT_SET) begin
            sw_set = bus.wdata;
        end
        if (bus.wr && bus.addr == ies_pkg::OFS_EVENT_CLEAR) begin
            sw_clr = bus.wdata;
        end
        // set after clear so that a coincident event survives
        ev_d = ((ev_q & ~sw_clr) | sw_set | hw_set) &
               ies_pkg::EVENT_IMPL;

        mask_d = mask_q;
        if (bus.wr && bus.addr == ies_pkg::OFS_MASK) begin
            mask_d = bus.wdata & ies_pkg::EVENT_IMPL;
        end

        ctrl_d = ctrl_q;
        if (bus.wr && bus.addr == ies_pkg::OFS_CTRL) begin
            ctrl_d = bus.wdata & ies_pkg::CTRL_IMPL;
        end
        if (overlong_fire) begin
            ctrl_d[ies_pkg::CTRL_CYC_SRC] = 1'b0;
        end

        blk_d = '0;
        if (ev_d[ies_pkg::BIT_FATAL]) begin
            blk_d = blk_q | ctx_halt;
        end

        irq_d = |(ev_d & mask_d);

        rdata_d = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                ies_pkg::OFS_EVENT_SET: begin
                    rdata_d = ev_q;
                end
                ies_pkg::OFS_EVENT_CLEAR: begin
                    rdata_d = ev_q & mask_q;
                end
                ies_pkg::OFS_MASK: begin
                    rdata_d = mask_q;
                end
                ies_pkg::OFS_CTRL: begin
                    rdata_d = ctrl_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_q    <= ies_pkg::EVENT_RESET;
            mask_q  <= ies_pkg::MASK_RESET;
            ctrl_q  <= ies_pkg::CTRL_RESET;
            rdata_q <= '0;
            irq_q   <= 1'b0;
            blk_q   <= '0;
            lsb_q   <= 1'b0;
            cs_q    <= CW_IDLE;
        end else if (clk_en) begin
            ev_q    <= ev_d;
            mask_q  <= mask_d;
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            blk_q   <= blk_d;
            lsb_q   <= lsb_d;
            cs_q    <= cs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_sw_set_takes: assert property (
        clk_en && bus.wr && bus.addr == ies_pkg::OFS_EVENT_SET
        |=> (ev_q & $past(bus.wdata) & ies_pkg::EVENT_IMPL) ==
            ($past(bus.wdata) & ies_pkg::EVENT_IMPL))
        else $error("set write did not set event bits");

    a_clear_only: assert property (
        clk_en && !(bus.wr && bus.addr == ies_pkg::OFS_EVENT_CLEAR)
        |=> ($past(ev_q) & ~ev_q) == 32'h0000_0000)
        else $error("event bit dropped without clear write");

    a_read_raw: assert property (
        clk_en && bus.rd && bus.addr == ies_pkg::OFS_EVENT_SET
        |=> rdata == $past(ev_q))
        else $error("set address read is not raw event");

    a_read_masked: assert property (
        clk_en && bus.rd && bus.addr == ies_pkg::OFS_EVENT_CLEAR
        |=> rdata == ($past(ev_q) & $past(mask_q)))
        else $error("clear address read is not masked event");

    a_reserved_zero: assert property (
        !rdata[31] && !rdata[28] && !ev_q[31] && !ev_q[28])
        else $error("reserved event bit not zero");

    a_late_ack_gate: assert property (
        clk_en && !late_en && !ev_q[ies_pkg::BIT_LATE_ACK] &&
        !(bus.wr && bus.addr == ies_pkg::OFS_EVENT_SET)
        |=> !ev_q[ies_pkg::BIT_LATE_ACK])
        else $error("late ack event set while reporting disabled");

    a_overlong_drop: assert property (
        clk_en && overlong_fire
        |=> !cycle_start_source && ev_q[ies_pkg::BIT_OVERLONG])
        else $error("overlong cycle did not drop cycle source");

    a_halt_block: assert property (
        context_block != '0 |-> ev_q[ies_pkg::BIT_FATAL])
        else $error("context blocked without fatal event");

    a_mismatch_set: assert property (
        clk_en && $past(clk_en) && mism_lvl && !$past(mism_lvl)
        |=> ev_q[ies_pkg::BIT_MISMATCH])
        else $error("cycle mismatch not recorded");

    a_tick_set: assert property (
        clk_en && $past(clk_en) && tick && !$past(tick)
        |=> ev_q[ies_pkg::BIT_TICK])
        else $error("cycle tick not recorded");

    a_irq_level: assert property (
        irq == |(ev_q & mask_q))
        else $error("interrupt output disagrees with masked events");

    a_set_wins: assert property (
        clk_en |=> (ev_q & $past(hw_set)) == $past(hw_set))
        else $error("hardware event lost");

    a_eeprom_event: assert property (
        clk_en && $past(clk_en) && src.eeprom_done && !$past(src.eeprom_done)
        |=> ev_q[ies_pkg::BIT_EEPROM])
        else $error("eeprom load done not recorded");

    a_soft_only_sw: assert property (
        clk_en && !ev_q[ies_pkg::BIT_SOFT] &&
        !(bus.wr && bus.addr == ies_pkg::OFS_EVENT_SET && bus.wdata[ies_pkg::BIT_SOFT])
        |=> !ev_q[ies_pkg::BIT_SOFT])
        else $error("software event set without set write");

    a_late_ack_event: assert property (
        clk_en && $past(clk_en) && late_en && $past(late_en) &&
        (src.rx_fifo_host_data || src.phys_resp_busy || src.ack_tardy_sent) &&
        !$past(src.rx_fifo_host_data) && !$past(src.phys_resp_busy) &&
        !$past(src.ack_tardy_sent)
        |=> ev_q[ies_pkg::BIT_LATE_ACK])
        else $error("late ack condition not recorded");

    a_phy_byte_event: assert property (
        clk_en && $past(clk_en) && src.phy_reg_byte_arrived &&
        !$past(src.phy_reg_byte_arrived)
        |=> ev_q[ies_pkg::BIT_PHY_REG])
        else $error("phy register byte not recorded");

    a_fatal_event: assert property (
        clk_en && $past(clk_en) && (ctx_halt != '0 || src.other_halt) &&
        $past(ctx_halt) == '0 && !$past(src.other_halt)
        |=> ev_q[ies_pkg::BIT_FATAL])
        else $error("halting error not recorded");

    a_block_follow: assert property (
        clk_en && ev_q[ies_pkg::BIT_FATAL] &&
        !(bus.wr && bus.addr == ies_pkg::OFS_EVENT_CLEAR && bus.wdata[ies_pkg::BIT_FATAL])
        |=> (context_block & $past(ctx_halt)) == $past(ctx_halt))
        else $error("halted context not blocked");

    a_lost_report: assert property (
        clk_en && $past(clk_en) && tick && (cs_q == CW_WAIT || cs_q == CW_GAP) &&
        !$past(lost_lvl)
        |=> ev_q[ies_pkg::BIT_MISSED])
        else $error("lost cycle not recorded");

    c_overlong: cover property (clk_en && overlong_fire);
    c_lost_predict: cover property (clk_en && lost_lvl && !tick);
    c_irq_rise: cover property (!irq ##1 irq);
    c_clear_race: cover property (clk_en && (sw_clr & hw_set) != '0);
endmodule // ies_event_reg

// file: ies_pkg.sv
// Overview of operation
// - event bit sets on source rising edge or on a one written at set address
// - event bit clears only by writing one at the clear address
// - reading the set address returns raw event bits
// - reading the clear address returns event bits anded with mask
// - bits 31 and 28 always read zero
// - bit 30 sets when serial eeprom loading completes
// - bit 29 is software only: set and cleared by software
// - bit 27 may set from its sources only while late ack reporting is enabled; a set write sets it always
// - bit 27 sets on host fifo data, busy response unit or tardy ack
// - bit 26 sets when a phy register byte is readable
// - as cycle source, bit 25 sets if start-to-gap-end exceeds 125 us
// - overlong cycle event clears the cycle start source bit 21
// - bit 24 sets when an error halts any subunit
// - while bit 24 is set, halted contexts' normal events are blocked
// - bit 23 sets when received cycle start disagrees with local timer
// - bit 22 sets when no cycle start falls between two ticks
// - bit 22 may set early when a loss is predicted
// - bit 20 tick sets whenever the cycle count lsb toggles
package ies_pkg;
    localparam logic [7:0]  OFS_EVENT_SET   = 8'h80;
    localparam logic [7:0]  OFS_EVENT_CLEAR = 8'h84;
    localparam logic [7:0]  OFS_MASK        = 8'h88;
    localparam logic [7:0]  OFS_CTRL        = 8'h8c;
    localparam int          BIT_EEPROM      = 30;
    localparam int          BIT_SOFT        = 29;
    localparam int          BIT_LATE_ACK    = 27;
    localparam int          BIT_PHY_REG     = 26;
    localparam int          BIT_OVERLONG    = 25;
    localparam int          BIT_FATAL       = 24;
    localparam int          BIT_MISMATCH    = 23;
    localparam int          BIT_MISSED      = 22;
    localparam int          BIT_TICK        = 20;
    localparam int          CTRL_LATE_EN    = 0;
    localparam int          CTRL_CYC_SRC    = 21;
    localparam logic [31:0] EVENT_IMPL      = 32'h6fd0_0000;
    localparam logic [31:0] EVENT_HW        = 32'h4fd0_0000;
    localparam logic [31:0] CTRL_IMPL       = 32'h0020_0001;
    localparam logic [31:0] EVENT_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam int          TIMER_CNT_LSB   = 12;
    localparam int          TIMER_SEC_LO    = 25;
    localparam int          TIMER_CNT_HI    = 24;
    localparam int          OVERLONG_US     = 125;
    localparam int          CLK_MHZ         = 100;
    localparam int          OVERLONG_CYCLES = OVERLONG_US * CLK_MHZ;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ies_bus_req_s;

    typedef struct packed {
        logic [31:0] local_timer;
        logic        tx_start_begin;
        logic        rx_start;
        logic [6:0]  rx_seconds;
        logic [12:0] rx_count;
        logic        gap_end;
        logic        arb_reset_gap;
    } ies_cycle_in_s;

    typedef struct packed {
        logic eeprom_done;
        logic rx_fifo_host_data;
        logic phys_resp_busy;
        logic ack_tardy_sent;
        logic phy_reg_byte_arrived;
        logic other_halt;
    } ies_src_s;
endpackage

// file: ies_edge_detect.sv
`timescale 1ns/1ns
module ies_edge_detect #(
    parameter int W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise
);
    if (W < 1) begin : g_chk
        $error("ies_edge_detect: W must be at least 1");
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic prev_q;
        logic prev_d;
        always_comb begin
            prev_d  = level[i];
            rise[i] = level[i] & ~prev_q;
        end
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                prev_q <= 1'b0;
            end else if (clk_en) begin
                prev_q <= prev_d;
            end
        end
    end
endmodule // ies_edge_detect

// file: ies_overlong_timer.sv
`timescale 1ns/1ns
module ies_overlong_timer #(
    parameter int LIMIT = 12500
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    input  wire logic enable,
    input  wire logic start,
    input  wire logic stop,
    output logic      fire
);
    localparam int CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);
    if (LIMIT < 1) begin : g_chk
        $error("ies_overlong_timer: LIMIT must be at least 1");
    end
    logic [CW-1:0] cnt_q, cnt_d;
    logic          run_q, run_d;
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        fire  = 1'b0;
        if (!enable || stop) begin
            run_d = 1'b0;
        end else if (start) begin
            run_d = 1'b1;
            cnt_d = '0;
        end else if (run_q) begin
            if (cnt_q == LIM) begin
                fire  = 1'b1;
                run_d = 1'b0;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end
endmodule // ies_overlong_timer

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int OVL = 20;

    logic                   ref_clk;
    logic                   arst_n;
    logic                   clk_en;
    ies_pkg::ies_bus_req_s  bus;
    ies_pkg::ies_src_s      src;
    ies_pkg::ies_cycle_in_s cyc;
    logic [7:0]             ctx_halt;
    logic [31:0]            rdata;
    logic                   irq;
    logic                   cycle_start_source;
    logic [7:0]             context_block;
    logic [31:0]            v;
    int                     miscompares;
    int                     check_count;

    ////////////////////////////////////////////////////////////////////////////////////////////
    ies_event_reg #(
        .N_CTX        (8),
        .OVERLONG_CYC (OVL)
    ) dut (
        .ref_clk            (ref_clk),
        .arst_n             (arst_n),
        .clk_en             (clk_en),
        .bus                (bus),
        .src                (src),
        .cyc                (cyc),
        .ctx_halt           (ctx_halt),
        .rdata              (rdata),
        .irq                (irq),
        .cycle_start_source (cycle_start_source),
        .context_block      (context_block)
    );

    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, d, exp);
    endtask

    task automatic clr_all;
        wr(8'h84, 32'hffff_ffff);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic rx_pulse(input logic [6:0] sec, input logic [12:0] cnt);
        @(posedge ref_clk);
        cyc.rx_start   <= 1'b1;
        cyc.rx_seconds <= sec;
        cyc.rx_count   <= cnt;
        @(posedge ref_clk);
        cyc.rx_start <= 1'b0;
    endtask

    task automatic tick;
        @(posedge ref_clk);
        cyc.local_timer <= cyc.local_timer ^ 32'h0000_1000;
    endtask

    task automatic gap_pulse;
        @(posedge ref_clk);
        cyc.gap_end <= 1'b1;
        @(posedge ref_clk);
        cyc.gap_end <= 1'b0;
    endtask

    function automatic logic [31:0] exp_ev(input int i, input int en);
        case (i)
            5:       return 32'h4000_0000;
            1:       return 32'h0400_0000;
            0:       return 32'h0100_0000;
            default: return (en == 1) ? 32'h0800_0000 : 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end

    initial begin
        ref_clk     = 1'b0;
        arst_n      = 1'b0;
        clk_en      = 1'b1;
        bus         = '0;
        src         = '0;
        cyc         = '0;
        ctx_halt    = 8'h00;
        miscompares = 0;
        check_count = 0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        // reset values and mask access
        chk_rd("event reset", 8'h80, ies_pkg::EVENT_RESET);
        chk_rd("mask reset", 8'h88, ies_pkg::MASK_RESET);
        chk_rd("ctrl reset", 8'h8c, ies_pkg::CTRL_RESET);
        wr(8'h88, 32'hffff_ffff);
        chk_rd("mask rw", 8'h88, ies_pkg::EVENT_IMPL);
        wr(8'h8c, 32'hffff_ffff);
        chk_rd("ctrl rw", 8'h8c, ies_pkg::CTRL_IMPL);
        wr(8'h8c, 32'h0000_0000);
        // software set, reserved bits, clear only by one at clear view
        wr(8'h80, 32'hffff_ffff);
        chk_rd("set view", 8'h80, ies_pkg::EVENT_IMPL);
        chk_rd("clear view", 8'h84, ies_pkg::EVENT_IMPL);
        wait_n(1);
        chk("irq high", {31'h0, irq}, 32'h1);
        wr(8'h84, 32'h0000_0000);
        wr(8'h80, 32'h0000_0000);
        chk_rd("zero writes", 8'h80, ies_pkg::EVENT_IMPL);
        wr(8'h84, 32'h2000_0000);
        chk_rd("clear one", 8'h80, ies_pkg::EVENT_IMPL & ~32'h2000_0000);
        clr_all();
        chk_rd("clear all", 8'h80, 32'h0000_0000);
        wait_n(2);
        chk("irq low", {31'h0, irq}, 32'h0);
        // frozen clock enable ignores a set write
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(8'h80, 32'h2000_0000);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        chk_rd("frozen write", 8'h80, 32'h0000_0000);
        // masked view against raw view
        wr(8'h88, 32'h2000_0000);
        wr(8'h80, 32'h2400_0000);
        chk_rd("masked view", 8'h84, 32'h2000_0000);
        chk_rd("raw view", 8'h80, 32'h2400_0000);
        @(posedge ref_clk);
        #1;
        chk("rdata idle", rdata, 32'h0000_0000);
        wr(8'h88, 32'h0400_0000);
        wait_n(2);
        chk("irq masked bit", {31'h0, irq}, 32'h1);
        wr(8'h88, 32'h0000_0000);
        wait_n(2);
        chk("irq all masked", {31'h0, irq}, 32'h0);
        chk_rd("unmapped read", 8'h90, 32'h0000_0000);
        wr(8'h90, 32'hffff_ffff);
        chk_rd("unmapped write", 8'h80, 32'h2400_0000);
        wr(8'h88, 32'hffff_ffff);
        clr_all();
        // each hardware source, late ack reporting off then on
        for (int en = 0; en < 2; en++) begin
            wr(8'h8c, {31'h0, en[0]});
            for (int i = 0; i < 6; i++) begin
                @(posedge ref_clk);
                src <= ies_pkg::ies_src_s'(6'h01 << i);
                chk_rd("source event", 8'h80, exp_ev(i, en));
                @(posedge ref_clk);
                src <= '0;
                clr_all();
            end
        end
        // clear in the same cycle as a new edge
        @(posedge ref_clk);
        src.eeprom_done <= 1'b1;
        @(posedge ref_clk);
        src.eeprom_done <= 1'b0;
        wait_n(2);
        @(posedge ref_clk);
        bus             <= '{addr: 8'h84, wdata: 32'h4000_0000, wr: 1'b1, rd: 1'b0};
        src.eeprom_done <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        chk_rd("clear vs edge", 8'h80, 32'h4000_0000);
        wait_n(3);
        chk_rd("level held", 8'h80, 32'h4000_0000);
        wr(8'h84, 32'h4000_0000);
        chk_rd("clear while high", 8'h80, 32'h0000_0000);
        @(posedge ref_clk);
        src <= '0;
        // halt blocking
        @(posedge ref_clk);
        ctx_halt <= 8'h04;
        wait_n(3);
        chk("context block", {24'h0, context_block}, 32'h0000_0004);
        chk_rd("halt event", 8'h80, 32'h0100_0000);
        wr(8'h84, 32'h0100_0000);
        wait_n(2);
        chk("block released", {24'h0, context_block}, 32'h0000_0000);
        @(posedge ref_clk);
        ctx_halt <= 8'h00;
        clr_all();
        // cycle start against local timer
        rx_pulse(7'h01, 13'h0000);
        chk_rd("timer mismatch", 8'h80, 32'h0080_0000);
        clr_all();
        rx_pulse(7'h00, 13'h0000);
        chk_rd("timer match", 8'h80, 32'h0000_0000);
        // ticks and lost cycles
        tick();
        wait_n(2);
        clr_all();
        rx_pulse(7'h00, 13'h0001);
        tick();
        chk_rd("tick with start", 8'h80, 32'h0010_0000);
        clr_all();
        tick();
        chk_rd("tick lost", 8'h80, 32'h0050_0000);
        clr_all();
        // early loss prediction, reported once
        @(posedge ref_clk);
        cyc.arb_reset_gap <= 1'b1;
        @(posedge ref_clk);
        cyc.arb_reset_gap <= 1'b0;
        chk_rd("reset gap loss", 8'h80, 32'h0040_0000);
        clr_all();
        tick();
        chk_rd("loss not repeated", 8'h80, 32'h0010_0000);
        clr_all();
        gap_pulse();
        gap_pulse();
        chk_rd("second gap loss", 8'h80, 32'h0040_0000);
        clr_all();
        // overlong cycle while cycle start source
        wr(8'h8c, 32'h0020_0000);
        wait_n(1);
        chk("source on", {31'h0, cycle_start_source}, 32'h1);
        @(posedge ref_clk);
        cyc.tx_start_begin <= 1'b1;
        @(posedge ref_clk);
        cyc.tx_start_begin <= 1'b0;
        wait_n(10);
        gap_pulse();
        wait_n(OVL + 10);
        rd(8'h80, v);
        chk("gap in time", v & 32'h0200_0000, 32'h0000_0000);
        chk("source kept", {31'h0, cycle_start_source}, 32'h1);
        @(posedge ref_clk);
        cyc.tx_start_begin <= 1'b1;
        @(posedge ref_clk);
        cyc.tx_start_begin <= 1'b0;
        wait_n(OVL + 10);
        rd(8'h80, v);
        chk("overlong", v & 32'h0200_0000, 32'h0200_0000);
        chk("source dropped", {31'h0, cycle_start_source}, 32'h0);
        chk_rd("ctrl after overlong", 8'h8c, 32'h0000_0000);
        stop_test();
    end
endmodule // tb_top
